// *** pdc_pll_divider.sv ***
// pll divider configuration registers with reference and feedback dividers
module pdc_pll_divider
  import pdc_pkg::*;
(
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  // wishbone slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic [31:0]      o_wb_dat,
  output logic             o_wb_ack,
  // counter rate enables, same clock domain
  input  wire logic        i_ref_tick,
  input  wire logic        i_vco_tick,
  // divider outputs and analog controls
  output logic             o_ref_div_pulse,
  output logic             o_fb_div_pulse,
  output logic             o_charge_pump_output_mid,
  output logic             o_ref_div_held,
  output logic             o_fb_div_held
);

  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  logic [7:0]  ref_lo_ff,  nxt_ref_lo;
  logic [5:0]  ref_hi_ff,  nxt_ref_hi;
  logic [5:0]  swal_ff,    nxt_swal;
  logic [7:0]  main_lo_ff, nxt_main_lo;
  logic [4:0]  main_hi_ff, nxt_main_hi;
  logic [7:0]  ctrl_ff,    nxt_ctrl;
  logic        ack_ff,     nxt_ack;
  logic [31:0] rdat_ff,    nxt_rdat;
  logic        pump_ff,    nxt_pump;
  logic        ref_hold_ff, nxt_ref_hold;
  logic        fb_hold_ff,  nxt_fb_hold;

  logic         req;
  logic         wr_en;
  logic [5:0]   idx;
  pdc_div_cfg_s cfg;
  pdc_pre_s     pre;
  logic [PDC_MAIN_W-1:0] main_eff;
  logic [PDC_FB_W-1:0]   fb_ratio;
  logic                  ref_div_pulse;
  logic                  fb_div_pulse;

  // new request only while no ack is out, so each access acks once
  assign req   = i_wb_cyc && i_wb_stb && !ack_ff;
  assign wr_en = req && i_wb_we && i_wb_sel[0];
  assign idx   = i_wb_adr[7:2];

  // ---------------------------------------------------------------
  // settings bundle
  // ---------------------------------------------------------------
  // ratio from both bytes
  assign cfg.ref_ratio = {ref_hi_ff, ref_lo_ff};
  assign cfg.swallow   = swal_ff;
  assign cfg.main      = {main_hi_ff, main_lo_ff};
  assign cfg.ctrl      = ctrl_ff;

  // ---------------------------------------------------------------
  // register writes and read data
  // ---------------------------------------------------------------
  // byte lane 0 carries the 8-bit registers; reserved bits dropped
  always_comb begin
    nxt_ref_lo  = ref_lo_ff;
    nxt_ref_hi  = ref_hi_ff;
    nxt_swal    = swal_ff;
    nxt_main_lo = main_lo_ff;
    nxt_main_hi = main_hi_ff;
    nxt_ctrl    = ctrl_ff;
    nxt_ack     = req;
    nxt_rdat    = rdat_ff;
    if (wr_en) begin
      case (idx)
        PDC_IDX_REF_LO:  nxt_ref_lo = i_wb_dat[7:0];
        PDC_IDX_REF_HI:  nxt_ref_hi = i_wb_dat[5:0];
        PDC_IDX_SWALLOW: nxt_swal = i_wb_dat[5:0];
        PDC_IDX_MAIN_LO: nxt_main_lo = i_wb_dat[7:0];
        PDC_IDX_MAIN_HI: nxt_main_hi = i_wb_dat[4:0];
        PDC_IDX_CTRL:    nxt_ctrl = i_wb_dat[7:0];
        default:         nxt_ctrl = ctrl_ff;
      endcase
    end
    if (req) begin
      case (idx)
        PDC_IDX_REF_LO:  nxt_rdat = {24'h000000, ref_lo_ff};
        PDC_IDX_REF_HI:  nxt_rdat = {26'h0000000, ref_hi_ff};
        PDC_IDX_SWALLOW: nxt_rdat = {26'h0000000, swal_ff};
        PDC_IDX_MAIN_LO: nxt_rdat = {24'h000000, main_lo_ff};
        PDC_IDX_MAIN_HI: nxt_rdat = {27'h0000000, main_hi_ff};
        PDC_IDX_CTRL:    nxt_rdat = {24'h000000, ctrl_ff};
        PDC_IDX_STATUS:  nxt_rdat = {29'h00000000, pump_ff, fb_hold_ff, ref_hold_ff};
        default:         nxt_rdat = 32'h00000000;
      endcase
    end
  end

  // register stage for the bus and settings
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ref_lo_ff  <= PDC_RST_REF_LO;
      ref_hi_ff  <= PDC_RST_REF_HI;
      swal_ff    <= PDC_RST_SWALLOW;
      main_lo_ff <= PDC_RST_MAIN_LO;
      main_hi_ff <= PDC_RST_MAIN_HI;
      ctrl_ff    <= PDC_RST_CTRL;
      ack_ff     <= 1'b0;
      rdat_ff    <= 32'h00000000;
    end else begin
      ref_lo_ff  <= nxt_ref_lo;
      ref_hi_ff  <= nxt_ref_hi;
      swal_ff    <= nxt_swal;
      main_lo_ff <= nxt_main_lo;
      main_hi_ff <= nxt_main_hi;
      ctrl_ff    <= nxt_ctrl;
      ack_ff     <= nxt_ack;
      rdat_ff    <= nxt_rdat;
    end
  end

  // ---------------------------------------------------------------
  // prescaler decode and feedback ratio
  // ---------------------------------------------------------------
  always_comb begin
    case (cfg.ctrl[PDC_PRE_MSB:0])
      3'h0:    pre = '{modulus: 6'h01, fixed_divide_mode: 1'b1};
      3'h1:    pre = '{modulus: 6'h02, fixed_divide_mode: 1'b1};
      3'h2:    pre = '{modulus: 6'h02, fixed_divide_mode: 1'b0};
      3'h3:    pre = '{modulus: 6'h04, fixed_divide_mode: 1'b0};
      3'h4:    pre = '{modulus: 6'h08, fixed_divide_mode: 1'b0};
      3'h5:    pre = '{modulus: 6'h10, fixed_divide_mode: 1'b0};
      3'h6:    pre = '{modulus: 6'h20, fixed_divide_mode: 1'b0};
      default: pre = '{modulus: 6'h03, fixed_divide_mode: 1'b1};
    endcase
  end

  // bypass in dual modulus is software's fault; swallow still added
  assign main_eff = cfg.ctrl[PDC_BIT_MAIN_BYP] ? PDC_MAIN_W'(1) : cfg.main;

  // total feedback ratio; swallow only counts in dual modulus
  // widen both factors first: 32 times a full main count overflows 13 bits
  assign fb_ratio = PDC_FB_W'(pre.modulus) * PDC_FB_W'(main_eff)
                  + (pre.fixed_divide_mode ? PDC_FB_W'(0) : PDC_FB_W'(cfg.swallow));

  // ---------------------------------------------------------------
  // counter holds and pump control
  // ---------------------------------------------------------------
  always_comb begin
    nxt_pump     = cfg.ctrl[PDC_BIT_PUMP_MID];
    nxt_ref_hold = cfg.ctrl[PDC_BIT_RST_REF] || cfg.ctrl[PDC_BIT_RST_ALL];
    nxt_fb_hold  = cfg.ctrl[PDC_BIT_RST_FB] || cfg.ctrl[PDC_BIT_RST_ALL];
  end

  // registered so the holds and pump level switch one cycle after a write
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      pump_ff     <= 1'b0;
      ref_hold_ff <= 1'b0;
      fb_hold_ff  <= 1'b0;
    end else begin
      pump_ff     <= nxt_pump;
      ref_hold_ff <= nxt_ref_hold;
      fb_hold_ff  <= nxt_fb_hold;
    end
  end

  // ---------------------------------------------------------------
  // dividers
  // ---------------------------------------------------------------
  // reference divider counts reference ticks
  pdc_div_counter #(
    .W (PDC_REF_W)
  ) u_ref_div (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_hold  (ref_hold_ff),
    .i_tick  (i_ref_tick),
    .i_ratio (cfg.ref_ratio),
    .o_pulse (ref_div_pulse)
  );

  pdc_div_counter #(
    .W (PDC_FB_W)
  ) u_fb_div (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_hold  (fb_hold_ff),
    .i_tick  (i_vco_tick),
    .i_ratio (fb_ratio),
    .o_pulse (fb_div_pulse)
  );

  // ---------------------------------------------------------------
  // outputs, all flip-flop driven
  // ---------------------------------------------------------------
  assign o_wb_ack                 = ack_ff;
  assign o_wb_dat                 = rdat_ff;
  assign o_ref_div_pulse          = ref_div_pulse;
  assign o_fb_div_pulse           = fb_div_pulse;
  assign o_charge_pump_output_mid = pump_ff;
  assign o_ref_div_held           = ref_hold_ff;
  assign o_fb_div_held            = fb_hold_ff;

endmodule // pdc_pll_divider

// *** pdc_pkg.sv ***
// constants and types shared by the divider configuration block
package pdc_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ---------------------------------------------------------------
  localparam logic [5:0] PDC_IDX_REF_LO  = 6'h11;
  localparam logic [5:0] PDC_IDX_REF_HI  = 6'h12;
  localparam logic [5:0] PDC_IDX_SWALLOW = 6'h13;
  localparam logic [5:0] PDC_IDX_MAIN_LO = 6'h14;
  localparam logic [5:0] PDC_IDX_MAIN_HI = 6'h15;
  localparam logic [5:0] PDC_IDX_CTRL    = 6'h16;
  localparam logic [5:0] PDC_IDX_STATUS  = 6'h18;

  // ---------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------
  localparam logic [7:0] PDC_RST_REF_LO  = 8'h01;
  localparam logic [5:0] PDC_RST_REF_HI  = 6'h00;
  localparam logic [5:0] PDC_RST_SWALLOW = 6'h00;
  localparam logic [7:0] PDC_RST_MAIN_LO = 8'h03;
  localparam logic [4:0] PDC_RST_MAIN_HI = 5'h00;
  localparam logic [7:0] PDC_RST_CTRL    = 8'h06;

  // ---------------------------------------------------------------
  // control register bit positions
  // ---------------------------------------------------------------
  localparam int PDC_BIT_PUMP_MID  = 7;
  localparam int PDC_BIT_RST_REF   = 6;
  localparam int PDC_BIT_RST_FB    = 5;
  localparam int PDC_BIT_RST_ALL   = 4;
  localparam int PDC_BIT_MAIN_BYP  = 3;
  localparam int PDC_PRE_MSB       = 2;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int PDC_REF_W  = 14;
  localparam int PDC_SWAL_W = 6;
  localparam int PDC_MAIN_W = 13;
  localparam int PDC_PRE_W  = 6;
  localparam int PDC_FB_W   = 20;

  // prescaler setting: modulus and fixed_divide_mode flag
  typedef struct packed {
    logic [PDC_PRE_W-1:0] modulus;
    logic                 fixed_divide_mode;
  } pdc_pre_s;

  // divider settings as seen by the counters
  typedef struct packed {
    logic [PDC_REF_W-1:0]  ref_ratio;
    logic [PDC_SWAL_W-1:0] swallow;
    logic [PDC_MAIN_W-1:0] main;
    logic [7:0]            ctrl;
  } pdc_div_cfg_s;

endpackage : pdc_pkg

// *** pdc_div_counter.sv ***
// programmable divider: one output pulse per ratio input ticks
module pdc_div_counter
  import pdc_pkg::*;
#(
  parameter int W = 14
) (
  // clock and reset
  input  wire logic         i_clock,
  input  wire logic         i_rst,
  // control
  input  wire logic         i_hold,
  input  wire logic         i_tick,
  input  wire logic [W-1:0] i_ratio,
  // divided output
  output logic              o_pulse
);

  logic [W-1:0] count_ff;
  logic [W-1:0] nxt_count;
  logic         pulse_ff;
  logic         nxt_pulse;
  logic [W-1:0] last;

  // ratio of zero behaves as divide-by-one rather than stalling
  assign last = (i_ratio == '0) ? '0 : i_ratio - W'(1);

  // next count and output pulse
  always_comb begin
    nxt_count = count_ff;
    nxt_pulse = 1'b0;
    if (i_hold) begin
      nxt_count = '0;
    end else if (i_tick) begin
      if (count_ff >= last) begin
        nxt_count = '0;
        nxt_pulse = 1'b1;
      end else begin
        nxt_count = count_ff + W'(1);
      end
    end
  end

  // register stage
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      count_ff <= '0;
      pulse_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      pulse_ff <= nxt_pulse;
    end
  end

  assign o_pulse = pulse_ff;

endmodule // pdc_div_counter

// *** pdc_pll_divider_sva.sv ***
// assertion checker for the divider configuration block
module pdc_pll_divider_sva
  import pdc_pkg::*;
(
  // clock and reset
  input wire logic        i_clock,
  input wire logic        i_rst,
  // wishbone side
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        i_wb_we,
  input wire logic [7:0]  i_wb_adr,
  input wire logic [3:0]  i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  // divider side
  input wire logic        i_ref_tick,
  input wire logic        i_vco_tick,
  input wire logic        o_ref_div_pulse,
  input wire logic        o_fb_div_pulse,
  input wire logic        o_charge_pump_output_mid,
  input wire logic        o_ref_div_held,
  input wire logic        o_fb_div_held
);
  // ---------------------------------------------------------------
  // helper terms
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  logic take;
  logic wr_ctrl;
  // a pending ack blocks a still-high strobe from being retaken
  assign take    = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign wr_ctrl = take && i_wb_we && i_wb_sel[0] && (i_wb_adr[7:2] == PDC_IDX_CTRL);
  sequence s_ctrl_wr;
    wr_ctrl ##1 1'b1;
  endsequence
  // control outputs lag the register by one cycle
  property p_ctl(logic o, logic v);
    s_ctrl_wr |=> o == $past(v, 2);
  endproperty
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  AST_ACK_NEXT: assert property (take |=> o_wb_ack)
    else $error("ack missing after request");
  AST_ACK_ONE: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (o_wb_ack |-> $past(take))
    else $error("ack without request");
  AST_UNMAP: assert property (take && !i_wb_we && i_wb_adr[7:2] == 6'h00 |=> o_wb_dat == 32'h0)
    else $error("unmapped read not zero");
  AST_PUMP: assert property (p_ctl(o_charge_pump_output_mid, i_wb_dat[7]))
    else $error("pump level wrong");
  AST_REF_HELD: assert property (p_ctl(o_ref_div_held, i_wb_dat[6] | i_wb_dat[4]))
    else $error("reference hold level wrong");
  AST_FB_HELD: assert property (p_ctl(o_fb_div_held, i_wb_dat[5] | i_wb_dat[4]))
    else $error("feedback hold level wrong");
  AST_REF_TICK: assert property (o_ref_div_pulse |-> $past(i_ref_tick))
    else $error("reference pulse without tick");
  AST_FB_TICK: assert property (o_fb_div_pulse |-> $past(i_vco_tick))
    else $error("feedback pulse without tick");
  AST_REF_HOLD: assert property (o_ref_div_held [*2] |=> !o_ref_div_pulse)
    else $error("reference pulse while held");
  AST_FB_HOLD: assert property (o_fb_div_held [*2] |=> !o_fb_div_pulse)
    else $error("feedback pulse while held");
endmodule // pdc_pll_divider_sva

bind pdc_pll_divider pdc_pll_divider_sva u_sva (.*);

// *** tb.sv ***
// self-checking testbench for the divider configuration block
module tb
  import pdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // signals and tables
  // ---------------------------------------------------------------
  logic        i_clock = 1'b0, i_rst = 1'b1, i_wb_cyc = 1'b0, i_wb_stb = 1'b0;
  logic        i_wb_we = 1'b0, i_ref_tick = 1'b0, i_vco_tick = 1'b0, o_wb_ack;
  logic [7:0]  i_wb_adr = 8'h00;
  logic [3:0]  i_wb_sel = 4'hF;
  logic [31:0] i_wb_dat = 32'h0, o_wb_dat, q;
  logic        o_ref_div_pulse, o_fb_div_pulse, o_charge_pump_output_mid;
  logic        o_ref_div_held, o_fb_div_held;
  int          n_errors = 0, samples_checked = 0, n_ref = 0, n_fb = 0, fr;
  logic [7:0]  rst_v [6] = '{8'h01, 8'h00, 8'h00, 8'h03, 8'h00, 8'h06};
  logic [7:0]  msk_v [5] = '{8'hFF, 8'h3F, 8'h3F, 8'hFF, 8'h1F};
  logic [7:0]  st_v [4]  = '{8'h04, 8'h01, 8'h02, 8'h03};
  int          prs [8]   = '{1, 2, 2, 4, 8, 16, 32, 3};

  pdc_pll_divider uut (.*);

  // clock and pulse counters
  always #2.5 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    n_ref <= n_ref + int'(o_ref_div_pulse === 1'b1);
    n_fb  <= n_fb + int'(o_fb_div_pulse === 1'b1);
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one classic cycle; bounded wait for ack, data taken at that edge
  task automatic wb(input logic [5:0] ix, input logic we, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge i_clock);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we  <= we;
    i_wb_adr <= {ix, 2'b00};
    i_wb_dat <= {24'h0, d};
    do begin
      @(posedge i_clock);
      k++;
    end while (o_wb_ack !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_errors++;
      close_out();
    end
    q = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
  endtask

  // clear counts through the hold-all bit, then tick n times
  task automatic div_case(input logic [7:0] c, input int n, input int er, input int ef);
    int r0, f0;
    wb(PDC_IDX_CTRL, 1'b1, 8'h10);
    wb(PDC_IDX_CTRL, 1'b1, c);
    repeat (3) @(posedge i_clock);
    r0 = n_ref;
    f0 = n_fb;
    repeat (n) begin
      @(posedge i_clock);
      i_ref_tick <= 1'b1;
      i_vco_tick <= 1'b1;
    end
    @(posedge i_clock);
    i_ref_tick <= 1'b0;
    i_vco_tick <= 1'b0;
    repeat (3) @(posedge i_clock);
    chk(n_ref - r0, er);
    chk(n_fb - f0, ef);
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      wb(PDC_IDX_REF_LO + 6'(i), 1'b0, 8'h00);
      chk(q, rst_v[i]);
    end
    $display("reset values test done");
    for (int i = 0; i < 5; i++) begin
      wb(PDC_IDX_REF_LO + 6'(i), 1'b1, 8'hFF);
      wb(PDC_IDX_REF_LO + 6'(i), 1'b0, 8'h00);
      chk(q, msk_v[i]);
    end
    i_wb_sel <= 4'hE;
    wb(PDC_IDX_REF_LO, 1'b1, 8'h55);
    i_wb_sel <= 4'hF;
    wb(PDC_IDX_REF_LO, 1'b0, 8'h00);
    chk(q, 32'h000000FF);
    wb(6'h00, 1'b1, 8'hA5);
    wb(6'h00, 1'b0, 8'h00);
    chk(q, 32'h0);
    $display("access test done");
    for (int j = 0; j < 4; j++) begin
      wb(PDC_IDX_CTRL, 1'b1, (8'h80 >> j) | 8'h06);
      repeat (2) @(posedge i_clock);
      wb(PDC_IDX_STATUS, 1'b0, 8'h00);
      chk(q, st_v[j]);
      chk({o_charge_pump_output_mid, o_fb_div_held, o_ref_div_held}, st_v[j]);
    end
    $display("control bit test done");
    wb(PDC_IDX_REF_LO, 1'b1, 8'h05);
    wb(PDC_IDX_REF_HI, 1'b1, 8'h00);
    wb(PDC_IDX_SWALLOW, 1'b1, 8'h03);
    wb(PDC_IDX_MAIN_LO, 1'b1, 8'h04);
    wb(PDC_IDX_MAIN_HI, 1'b1, 8'h00);
    for (int p = 0; p < 8; p++) begin
      fr = prs[p] * 4 + ((p >= 2 && p <= 6) ? 3 : 0);
      div_case(8'(p), 3 * fr - 1, (3 * fr - 1) / 5, 2);
    end
    div_case(8'h09, 5, 1, 2);
    div_case(8'h41, 17, 0, 2);
    div_case(8'h21, 17, 3, 0);
    div_case(8'h11, 17, 0, 0);
    wb(PDC_IDX_REF_LO, 1'b1, 8'h02);
    wb(PDC_IDX_REF_HI, 1'b1, 8'h01);
    wb(PDC_IDX_MAIN_LO, 1'b1, 8'h01);
    wb(PDC_IDX_MAIN_HI, 1'b1, 8'h01);
    div_case(8'h00, 771, 2, 3);
    div_case(8'h06, 16454, 63, 2);
    $display("divider test done");
    close_out();
  end
endmodule // tb
